// ---- include/lifetime_logger_consts.vh ----
// Constants for the lifetime min/max logger: table layout, access codes,
// reset values and the one-second timebase. Definitions only.
`ifndef LIFETIME_LOGGER_CONSTS_VH
`define LIFETIME_LOGGER_CONSTS_VH

// Subcommand that turns tracking on
`define LTL_CMD_TRACK_EN      16'h0021
// Host access selectors
`define LTL_SUBCLASS_DATA     8'h3b
`define LTL_SUBCLASS_RES      8'h42
`define LTL_BLOCK_LIFETIME    8'h04
// Lifetime data words (32 bytes) and resolution words
`define LTL_DATA_WORDS        6'h10
`define LTL_RES_WORDS         6'h04
// Extremes table word indices
`define LTL_W_MAXV            3'h0
`define LTL_W_MINV            3'h1
`define LTL_W_MAXI            3'h2
`define LTL_W_MINI            3'h3
`define LTL_W_MAXT            3'h4
`define LTL_W_MINT            3'h5
`define LTL_EXT_WORDS         3'h6
// Resolution block word indices
`define LTL_R_TEMP            2'h0
`define LTL_R_VOLT            2'h1
`define LTL_R_CURR            2'h2
`define LTL_R_INTERVAL        2'h3
// Resolution reset values
`define LTL_RST_TEMP_RES      16'h000a
`define LTL_RST_VOLT_RES      16'h0064
`define LTL_RST_CURR_RES      16'h0064
`define LTL_RST_INTERVAL      16'h003c
// Learning-status codes
`define LTL_ST_GOLDEN         8'h02
`define LTL_ST_ENABLED        8'h04
`define LTL_ST_CAP_ONLY       8'h05
`define LTL_ST_LEARNED        8'h06
// Timebase
`define LTL_SECOND_NS         1000000000
`define LTL_CLK_PERIOD_NS     4
`define LTL_CYCLES_PER_SEC    (`LTL_SECOND_NS / `LTL_CLK_PERIOD_NS)

`endif

// ---- src/lifetime_table_mem.v ----
// Single-port store standing in for the lifetime data flash block.
// Assumes one access per cycle; read data is registered, one cycle late.
`timescale 1ns/1ps
`default_nettype none

module lifetime_table_mem #(
  parameter DW = 16,
  parameter AW = 4
) (
  input  wire          sys_clk,
  input  wire          en,
  input  wire          we,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wrData,
  output reg  [DW-1:0] rdData_q
);

  reg [DW-1:0] store [0:(1<<AW)-1];

  // Nonvolatile contents: no reset on purpose
  always @(posedge sys_clk) begin
    if (en && we) begin
      store[addr] <= wrData;
    end
    if (en) begin
      rdData_q <= store[addr];
    end
  end

endmodule
`default_nettype wire

// ---- src/lifetime_minmax_logger.v ----
// Lifetime min/max logger: RAM extremes table, windowed flash copy,
// learning-status code and host data-flash block access.
// Assumes all inputs synchronous to sys_clk and one-cycle request pulses.
`timescale 1ns/1ps
`default_nettype none
`include "lifetime_logger_consts.vh"

module lifetime_minmax_logger #(
  parameter       CYCLES_PER_SEC = `LTL_CYCLES_PER_SEC,
  parameter [7:0] STATUS_RESET   = `LTL_ST_GOLDEN
) (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        subcmdValid,
  input  wire [15:0] subcmdCode,
  input  wire        capLearned,
  input  wire        resLearned,
  input  wire        measValid,
  input  wire [15:0] measVolt,
  input  wire [15:0] measCurr,
  input  wire [15:0] measTemp,
  input  wire        sealed,
  input  wire        hostReq,
  input  wire        hostWrite,
  input  wire [7:0]  hostSubclass,
  input  wire [7:0]  hostBlockSel,
  input  wire [4:0]  hostAddr,
  input  wire [15:0] hostWrData,
  output reg  [15:0] hostRdData_q,
  output reg         hostAck_q,
  output reg         hostErr_q,
  output reg         busy_q,
  output reg         trackingEnable_q,
  output reg  [7:0]  updateStatus_q,
  output reg         loggingActive_q,
  output reg         windowOpen_q,
  output reg         flashCopyDone_q
);

  localparam [1:0] ST_LOAD = 2'h0;
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_COPY = 2'h2;
  localparam [1:0] ST_HRD  = 2'h3;
  localparam [31:0] TICK_FULL = CYCLES_PER_SEC - 1;
  localparam [27:0] TICK_LAST = TICK_FULL[27:0];

  // Strict "a above b by more than res"
  function beyond;
    input [15:0] a;
    input [15:0] b;
    input [15:0] res;
    reg   [16:0] diff;
    begin
      diff = {1'b0, a} - {1'b0, b};
      beyond = (a > b) && (diff > {1'b0, res});
    end
  endfunction

  reg [1:0]  state_q;
  reg [2:0]  idx_q;
  reg [15:0] ramTab   [0:5];
  reg [15:0] flashTab [0:5];
  reg [15:0] tempRes_q;
  reg [15:0] voltRes_q;
  reg [15:0] currRes_q;
  reg [15:0] interval_q;
  reg [27:0] tickCnt_q;
  reg [15:0] secLeft_q;
  reg        copyPend_q;

  reg        memEn;
  reg        memWe;
  reg [3:0]  memAddr;
  reg [15:0] memWrData;
  wire [15:0] memRdData;

  wire [15:0] measArr [0:2];
  wire [15:0] resArr  [0:2];
  assign measArr[0] = measVolt;
  assign measArr[1] = measCurr;
  assign measArr[2] = measTemp;
  assign resArr[0]  = voltRes_q;
  assign resArr[1]  = currRes_q;
  assign resArr[2]  = tempRes_q;

  wire active = trackingEnable_q && (interval_q != 16'h0000);

  // Host request decode
  wire hostTake  = hostReq && (state_q == ST_IDLE) && !copyPend_q;
  wire sealedOk  = sealed && (hostBlockSel == `LTL_BLOCK_LIFETIME) &&
                   ({1'b0, hostAddr} < `LTL_DATA_WORDS);
  wire dataOk    = !sealed && (hostSubclass == `LTL_SUBCLASS_DATA) &&
                   ({1'b0, hostAddr} < `LTL_DATA_WORDS);
  wire resOk     = !sealed && (hostSubclass == `LTL_SUBCLASS_RES) &&
                   ({1'b0, hostAddr} < `LTL_RES_WORDS);
  wire flashHit  = hostTake && (sealedOk || dataOk);
  wire restartWr = hostTake && hostWrite && sealedOk &&
                   (hostAddr[3:0] < {1'b0, `LTL_EXT_WORDS});

  reg newExtreme;
  integer p;
  always @* begin
    newExtreme = 1'b0;
    for (p = 0; p < 3; p = p + 1) begin
      if (beyond(measArr[p], flashTab[2*p], resArr[p]) ||
          beyond(flashTab[2*p+1], measArr[p], resArr[p])) begin
        newExtreme = 1'b1;
      end
    end
  end

  wire measLive = measValid && active && (state_q != ST_LOAD);
  wire tick     = windowOpen_q && (tickCnt_q == TICK_LAST);
  wire winEnd   = tick && (secLeft_q == 16'h0001);

  // Memory port shared by reload, copy and host access
  always @* begin
    memEn     = 1'b0;
    memWe     = 1'b0;
    memAddr   = hostAddr[3:0];
    memWrData = hostWrData;
    case (state_q)
      ST_LOAD: begin
        memEn   = 1'b1;
        memAddr = {1'b0, idx_q};
      end
      ST_COPY: begin
        memEn     = 1'b1;
        memWe     = 1'b1;
        memAddr   = {1'b0, idx_q};
        memWrData = ramTab[idx_q];
      end
      ST_IDLE: begin
        memEn = flashHit;
        memWe = flashHit && hostWrite;
      end
      default: begin
        memEn = 1'b0;
      end
    endcase
  end

  lifetime_table_mem #(
    .DW (16),
    .AW (4)
  ) u_table (
    .sys_clk  (sys_clk),
    .en       (memEn),
    .we       (memWe),
    .addr     (memAddr),
    .wrData   (memWrData),
    .rdData_q (memRdData)
  );

  // Sequencer: reload after reset, copy, host access
  integer k;
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q         <= ST_LOAD;
      idx_q           <= 3'h0;
      busy_q          <= 1'b1;
      hostAck_q       <= 1'b0;
      hostErr_q       <= 1'b0;
      hostRdData_q    <= 16'h0000;
      flashCopyDone_q <= 1'b0;
      tempRes_q       <= `LTL_RST_TEMP_RES;
      voltRes_q       <= `LTL_RST_VOLT_RES;
      currRes_q       <= `LTL_RST_CURR_RES;
      interval_q      <= `LTL_RST_INTERVAL;
      for (k = 0; k < 6; k = k + 1) begin
        ramTab[k]   <= 16'h0000;
        flashTab[k] <= 16'h0000;
      end
    end else begin
      hostAck_q       <= 1'b0;
      hostErr_q       <= 1'b0;
      flashCopyDone_q <= 1'b0;
      if (measLive) begin
        for (k = 0; k < 3; k = k + 1) begin
          if (measArr[k] > ramTab[2*k]) begin
            ramTab[2*k] <= measArr[k];
          end
          if (measArr[k] < ramTab[2*k+1]) begin
            ramTab[2*k+1] <= measArr[k];
          end
        end
      end
      case (state_q)
        ST_LOAD: begin
          if (idx_q != 3'h0) begin
            ramTab[idx_q - 3'h1]   <= memRdData;
            flashTab[idx_q - 3'h1] <= memRdData;
          end
          if (idx_q == `LTL_EXT_WORDS) begin
            state_q <= ST_IDLE;
            idx_q   <= 3'h0;
            busy_q  <= 1'b0;
          end else begin
            idx_q <= idx_q + 3'h1;
          end
        end
        ST_COPY: begin
          flashTab[idx_q] <= ramTab[idx_q];
          if (idx_q == `LTL_EXT_WORDS - 3'h1) begin
            state_q         <= ST_IDLE;
            idx_q           <= 3'h0;
            busy_q          <= 1'b0;
            flashCopyDone_q <= 1'b1;
          end else begin
            idx_q <= idx_q + 3'h1;
          end
        end
        ST_HRD: begin
          hostRdData_q <= memRdData;
          hostAck_q    <= 1'b1;
          busy_q       <= 1'b0;
          state_q      <= ST_IDLE;
        end
        ST_IDLE: begin
          if (copyPend_q) begin
            state_q <= ST_COPY;
            idx_q   <= 3'h0;
            busy_q  <= 1'b1;
          end else if (hostTake) begin
            if (flashHit && !hostWrite) begin
              state_q <= ST_HRD;
              busy_q  <= 1'b1;
            end else begin
              hostAck_q <= 1'b1;
              hostErr_q <= !(sealedOk || dataOk || resOk);
            end
            if (resOk && hostWrite) begin
              case (hostAddr[1:0])
                `LTL_R_TEMP: tempRes_q  <= hostWrData;
                `LTL_R_VOLT: voltRes_q  <= hostWrData;
                `LTL_R_CURR: currRes_q  <= hostWrData;
                default:     interval_q <= hostWrData;
              endcase
            end else if (resOk) begin
              case (hostAddr[1:0])
                `LTL_R_TEMP: hostRdData_q <= tempRes_q;
                `LTL_R_VOLT: hostRdData_q <= voltRes_q;
                `LTL_R_CURR: hostRdData_q <= currRes_q;
                default:     hostRdData_q <= interval_q;
              endcase
            end
            if (restartWr) begin
              ramTab[hostAddr[2:0]]   <= hostWrData;
              flashTab[hostAddr[2:0]] <= hostWrData;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Update window timing
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      windowOpen_q    <= 1'b0;
      tickCnt_q       <= 28'h0000000;
      secLeft_q       <= 16'h0000;
      copyPend_q      <= 1'b0;
      loggingActive_q <= 1'b0;
    end else begin
      loggingActive_q <= active;
      if (state_q == ST_IDLE && copyPend_q) begin
        copyPend_q <= 1'b0;
      end
      if (!active) begin
        // Abandoned window: closed without setting a table copy to flash
        windowOpen_q <= 1'b0;
        tickCnt_q    <= 28'h0000000;
      end else if (windowOpen_q) begin
        tickCnt_q <= tick ? 28'h0000000 : tickCnt_q + 28'h0000001;
        if (tick) begin
          secLeft_q <= secLeft_q - 16'h0001;
        end
        if (winEnd) begin
          windowOpen_q <= 1'b0;
          copyPend_q   <= 1'b1;
        end
      end else if (measLive && newExtreme) begin
        windowOpen_q <= 1'b1;
        tickCnt_q    <= 28'h0000000;
        secLeft_q    <= interval_q;
      end
    end
  end

  // Learning status, never written by the host
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      trackingEnable_q <= 1'b0;
      updateStatus_q   <= STATUS_RESET;
    end else begin
      if (subcmdValid && subcmdCode == `LTL_CMD_TRACK_EN) begin
        trackingEnable_q <= 1'b1;
        if (updateStatus_q == `LTL_ST_GOLDEN) begin
          updateStatus_q <= `LTL_ST_LEARNED;
        end else if (updateStatus_q < `LTL_ST_ENABLED) begin
          updateStatus_q <= `LTL_ST_ENABLED;
        end
      end else if (trackingEnable_q) begin
        if (capLearned && updateStatus_q == `LTL_ST_ENABLED) begin
          updateStatus_q <= `LTL_ST_CAP_ONLY;
        end else if (resLearned && updateStatus_q == `LTL_ST_CAP_ONLY) begin
          updateStatus_q <= `LTL_ST_LEARNED;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- dv/logger_check_assertions.sv ----
// Checker for the lifetime logger: host answers, status code, update window.
// Assumes binding to the logger top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module logger_check #(
  parameter CYCLES_PER_SEC = 10
) (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        subcmdValid,
  input wire logic [15:0] subcmdCode,
  input wire logic        capLearned,
  input wire logic        resLearned,
  input wire logic        sealed,
  input wire logic        hostReq,
  input wire logic [7:0]  hostSubclass,
  input wire logic [7:0]  hostBlockSel,
  input wire logic [4:0]  hostAddr,
  input wire logic        hostAck_q,
  input wire logic        hostErr_q,
  input wire logic        busy_q,
  input wire logic        trackingEnable_q,
  input wire logic [7:0]  updateStatus_q,
  input wire logic        loggingActive_q,
  input wire logic        windowOpen_q,
  input wire logic        flashCopyDone_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [31:0] winCnt_q;
  logic [31:0] winCnt_d;
  assign winCnt_d = windowOpen_q ? winCnt_q + 32'h1 : 32'h0;
  always @(posedge sys_clk) winCnt_q <= sys_rst ? 32'h0 : winCnt_d;
  // A request just as a window ends is dropped, not answered: the copy goes first
  sequence s_take; hostReq && !busy_q && !$fell(windowOpen_q); endsequence
  sequence s_copy; busy_q ##[1:10] flashCopyDone_q; endsequence
  property p_ack; s_take |-> ##[1:2] hostAck_q; endproperty
  property p_data;
    s_take ##0 (!sealed && hostSubclass == 8'h3b && hostAddr < 5'h10)
      |-> ##[1:2] (hostAck_q && !hostErr_q);
  endproperty
  property p_blk; s_take ##0 (sealed && hostBlockSel != 8'h04) |=> hostAck_q && hostErr_q;
  endproperty
  property p_len;
    s_take ##0 (sealed && hostBlockSel == 8'h04 && hostAddr > 5'h0f) |=> hostErr_q;
  endproperty
  property p_res;
    s_take ##0 (!sealed && hostSubclass == 8'h42 && hostAddr > 5'h03) |=> hostErr_q;
  endproperty
  property p_track; subcmdValid && subcmdCode == 16'h0021 |=> trackingEnable_q; endproperty
  property p_gate; !trackingEnable_q |=> !loggingActive_q; endproperty
  property p_stat;
    !subcmdValid && !capLearned && !resLearned |=> $stable(updateStatus_q);
  endproperty
  property p_cap;
    capLearned && trackingEnable_q && updateStatus_q == 8'h04 |=> updateStatus_q == 8'h05;
  endproperty
  property p_win;
    $fell(windowOpen_q) |-> winCnt_q != 0 && winCnt_q % CYCLES_PER_SEC == 0;
  endproperty
  property p_copy; $fell(windowOpen_q) |=> s_copy; endproperty
  a_ack: assert property (p_ack)
    else $error("host request not answered");
  a_data: assert property (p_data)
    else $error("unsealed data access refused");
  a_blk: assert property (p_blk)
    else $error("sealed wrong block not refused");
  a_len: assert property (p_len)
    else $error("sealed access past 32 bytes not refused");
  a_res: assert property (p_res)
    else $error("bad resolution word not refused");
  a_track: assert property (p_track)
    else $error("enable subcommand ignored");
  a_gate: assert property (p_gate)
    else $error("logging active without tracking");
  a_stat: assert property (p_stat)
    else $error("status changed without cause");
  a_cap: assert property (p_cap)
    else $error("capacity learning not reflected");
  a_win: assert property (p_win)
    else $error("window length wrong");
  a_copy: assert property (p_copy)
    else $error("no table copy after window");
endmodule
bind lifetime_minmax_logger logger_check #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) chk (
  .sys_clk, .sys_rst, .subcmdValid, .subcmdCode, .capLearned, .resLearned, .sealed,
  .hostReq, .hostSubclass, .hostBlockSel, .hostAddr, .hostAck_q, .hostErr_q, .busy_q,
  .trackingEnable_q, .updateStatus_q, .loggingActive_q, .windowOpen_q, .flashCopyDone_q);
`default_nettype wire

// ---- dv/host_model.sv ----
// Host side of the data-flash access port, one request at a time.
// Assumes one-cycle request pulses and a one-cycle acknowledge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        sys_clk,
  input  wire logic        busy_q,
  input  wire logic        hostAck_q,
  input  wire logic        hostErr_q,
  input  wire logic [15:0] hostRdData_q,
  output var  logic        hostReq,
  output var  logic        hostWrite,
  output var  logic [7:0]  hostSubclass,
  output var  logic [7:0]  hostBlockSel,
  output var  logic [4:0]  hostAddr,
  output var  logic [15:0] hostWrData
);
  initial begin
    hostReq = 1'b0;
    hostWrite = 1'b0;
    hostSubclass = 8'h00;
    hostBlockSel = 8'h00;
    hostAddr = 5'h00;
    hostWrData = 16'h0000;
  end
  task automatic acc(input logic w, input logic [7:0] sc, input logic [7:0] bs,
                     input logic [4:0] a, input logic [15:0] d,
                     output logic [15:0] rd, output logic er);
    int n;
    n = 0;
    @(negedge sys_clk);
    // Busy drops requests silently
    while (busy_q && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    hostReq = 1'b1;
    hostWrite = w;
    hostSubclass = sc;
    hostBlockSel = bs;
    hostAddr = a;
    hostWrData = d;
    @(negedge sys_clk);
    hostReq = 1'b0;
    // Released lines must not look valid
    hostAddr = ~a;
    hostWrData = ~d;
    n = 0;
    while (!hostAck_q && n < 4) begin
      @(negedge sys_clk);
      n++;
    end
    rd = hostAck_q ? hostRdData_q : 16'hxxxx;
    er = hostAck_q ? hostErr_q : 1'bx;
  endtask
endmodule
`default_nettype wire

// ---- dv/lifetime_minmax_logger_test.sv ----
// Self-checking bench for the lifetime logger.
// Assumes a shortened second of 10 cycles and status reset 0x00.
`timescale 1ns/1ps
`default_nettype none
`include "lifetime_logger_consts.vh"
module lifetime_minmax_logger_test;
  localparam CPS = 10;
  localparam [7:0] D = `LTL_SUBCLASS_DATA;
  localparam [7:0] R = `LTL_SUBCLASS_RES;
  localparam [7:0] B = `LTL_BLOCK_LIFETIME;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        subcmdValid = 1'b0;
  logic [15:0] subcmdCode = 16'h0000;
  logic        capLearned = 1'b0;
  logic        resLearned = 1'b0;
  logic        measValid = 1'b0;
  logic [15:0] measVolt = 16'h0000;
  logic [15:0] measCurr = 16'h0000;
  logic [15:0] measTemp = 16'h0000;
  logic        sealed = 1'b0;
  logic        hostReq, hostWrite;
  logic [7:0]  hostSubclass, hostBlockSel;
  logic [4:0]  hostAddr;
  logic [15:0] hostWrData, rd;
  logic        er;
  wire  [15:0] hostRdData_q;
  wire  [7:0]  updateStatus_q;
  wire         hostAck_q, hostErr_q, busy_q, trackingEnable_q;
  wire         loggingActive_q, windowOpen_q, flashCopyDone_q;
  int          n_mismatch = 0;
  int          checks = 0;
  always #2 sys_clk = ~sys_clk;
  lifetime_minmax_logger #(.CYCLES_PER_SEC(CPS), .STATUS_RESET(8'h00)) uut (
    .sys_clk, .sys_rst, .subcmdValid, .subcmdCode, .capLearned, .resLearned, .measValid,
    .measVolt, .measCurr, .measTemp, .sealed, .hostReq, .hostWrite, .hostSubclass,
    .hostBlockSel, .hostAddr, .hostWrData, .hostRdData_q, .hostAck_q, .hostErr_q, .busy_q,
    .trackingEnable_q, .updateStatus_q, .loggingActive_q, .windowOpen_q, .flashCopyDone_q);
  host_model host (.sys_clk, .busy_q, .hostAck_q, .hostErr_q, .hostRdData_q, .hostReq,
    .hostWrite, .hostSubclass, .hostBlockSel, .hostAddr, .hostWrData);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_reset();
    int n;
    n = 0;
    @(negedge sys_clk);
    sys_rst = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk(busy_q, 1'b1);
    chk(updateStatus_q, 8'h00);
    chk(trackingEnable_q, 1'b0);
    sys_rst = 1'b0;
    while (busy_q && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk(busy_q, 1'b0);
  endtask
  task automatic meas(input logic [15:0] v, input logic [15:0] t);
    @(negedge sys_clk);
    measValid = 1'b1;
    measVolt = v;
    measCurr = 16'h0032;
    measTemp = t;
    @(negedge sys_clk);
    measValid = 1'b0;
  endtask
  task automatic pulse(input logic s, input logic c, input logic r, input logic [15:0] k);
    @(negedge sys_clk);
    subcmdValid = s;
    subcmdCode = k;
    capLearned = c;
    resLearned = r;
    @(negedge sys_clk);
    subcmdValid = 1'b0;
    capLearned = 1'b0;
    resLearned = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic t_access();
    host.acc(1'b1, D, 8'h00, 5'h06, 16'h1234, rd, er);
    host.acc(1'b0, D, 8'h00, 5'h06, 16'h0000, rd, er);
    chk(rd, 16'h1234);
    host.acc(1'b1, D, 8'h00, 5'h10, 16'h0000, rd, er);
    chk(er, 1'b1);
    host.acc(1'b1, R, 8'h00, 5'h03, 16'h0000, rd, er);
    host.acc(1'b0, R, 8'h00, 5'h03, 16'hffff, rd, er);
    chk(rd, 16'h0000);
    host.acc(1'b1, R, 8'h00, 5'h04, 16'h0000, rd, er);
    chk(er, 1'b1);
    sealed = 1'b1;
    host.acc(1'b1, R, 8'h00, 5'h03, 16'h0001, rd, er);
    chk(er, 1'b1);
    host.acc(1'b0, D, B, 5'h06, 16'h0000, rd, er);
    chk(rd, 16'h1234);
    host.acc(1'b0, D, 8'h03, 5'h06, 16'h0000, rd, er);
    chk(er, 1'b1);
    host.acc(1'b0, D, B, 5'h10, 16'h0000, rd, er);
    chk(er, 1'b1);
    sealed = 1'b0;
    host.acc(1'b0, R, 8'h00, 5'h03, 16'hffff, rd, er);
    chk(rd, 16'h0000);
  endtask
  task automatic t_status();
    host.acc(1'b1, R, 8'h00, 5'h03, 16'h0000, rd, er);
    pulse(1'b0, 1'b1, 1'b0, 16'h0000);
    chk(updateStatus_q, 8'h00);
    pulse(1'b1, 1'b0, 1'b0, 16'h0022);
    chk(trackingEnable_q, 1'b0);
    pulse(1'b1, 1'b0, 1'b0, `LTL_CMD_TRACK_EN);
    chk(updateStatus_q, `LTL_ST_ENABLED);
    pulse(1'b0, 1'b0, 1'b1, 16'h0000);
    chk(updateStatus_q, `LTL_ST_ENABLED);
    pulse(1'b0, 1'b1, 1'b0, 16'h0000);
    chk(updateStatus_q, `LTL_ST_CAP_ONLY);
    pulse(1'b0, 1'b0, 1'b1, 16'h0000);
    chk(updateStatus_q, `LTL_ST_LEARNED);
    meas(16'h0fff, 16'h00ff);
    repeat (3) @(negedge sys_clk);
    chk(windowOpen_q, 1'b0);
    chk(loggingActive_q, 1'b0);
  endtask
  task automatic t_window();
    int n;
    sealed = 1'b1;
    for (n = 0; n < 6; n++)
      host.acc(1'b1, D, B, n[4:0], n < 2 ? 16'h0064 : n < 4 ? 16'h0032 : 16'h001e, rd, er);
    meas(16'h00c8, 16'h001e);
    repeat (3) @(negedge sys_clk);
    chk(windowOpen_q, 1'b0);
    meas(16'h00c9, 16'h001e);
    chk(windowOpen_q, 1'b1);
    meas(16'h00fa, 16'h0023);
    n = 3;
    while (windowOpen_q && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n >= CPS && n <= CPS + 2, 1'b1);
    n = 0;
    while (!flashCopyDone_q && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk(flashCopyDone_q, 1'b1);
    host.acc(1'b0, D, B, 5'h00, 16'h0000, rd, er);
    chk(rd, 16'h00fa);
    host.acc(1'b0, D, B, 5'h04, 16'h0000, rd, er);
    chk(rd, 16'h0023);
    meas(16'h01f4, 16'h001e);
    chk(windowOpen_q, 1'b1);
  endtask
  initial begin
    do_reset();
    // Known flash baseline; unsealed writes act only after reset
    for (int w = 0; w < 6; w++)
      host.acc(1'b1, D, 8'h00, w[4:0], w < 2 ? 16'h0064 : w < 4 ? 16'h0032 : 16'h001e, rd, er);
    do_reset();
    meas(16'h0fff, 16'h00ff);
    repeat (3) @(negedge sys_clk);
    chk(windowOpen_q, 1'b0);
    t_access();
    do_reset();
    t_status();
    do_reset();
    // Interval is a plain register: set after reset
    host.acc(1'b1, R, 8'h00, 5'h03, 16'h0001, rd, er);
    pulse(1'b1, 1'b0, 1'b0, `LTL_CMD_TRACK_EN);
    chk(loggingActive_q, 1'b1);
    t_window();
    report_and_stop();
  end
  initial begin
    #40000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire
